/* File: sim/can_link_model.sv */
`timescale 1ns/100ps
module can_link_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [28:0] id_i,
  input wire logic ext_i,
  input wire logic [3:0] dlc_i,
  input wire logic [63:0] data_i,
  input wire logic stall_i,
  output logic ready_o
);
  logic [28:0] q_id[$];
  logic q_ext[$];
  logic [63:0] q_data[$];
  int q_t[$];
  int cyc = 0;
  int bad = 0;
  initial ready_o = 1'b0;
  // slow partner: bench holds stall_i to keep frames waiting
  always @(negedge clk_i) ready_o <= !stall_i;
  always @(posedge clk_i) begin
    cyc++;
    if (valid_i && ready_o) begin
      q_id.push_back(id_i);
      q_ext.push_back(ext_i);
      q_data.push_back(data_i);
      q_t.push_back(cyc);
      if (dlc_i != 4'h8 || (!ext_i && id_i > 29'h7FF)) bad++;
    end
  end
endmodule : can_link_model

/* File: sim/can_page_broadcaster_properties.sv */
`timescale 1ns/100ps
module can_page_broadcaster_properties (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [28:0] tx_id_o,
  input wire logic tx_ext_o,
  input wire logic [3:0] tx_dlc_o,
  input wire logic [63:0] tx_data_o,
  input wire logic [7:0] bit_cycles_o,
  input wire logic rx_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [63:0] rx_data_i,
  input wire logic cmd_valid_o,
  input wire logic [15:0] cmd_data_o,
  input wire logic [2:0] page_o,
  input wire logic [8:0] tsc1_sa_cfg_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic acc;
  logic [15:0] rx_lo;
  assign acc = rx_valid_i && !rx_ext_i && rx_id_i[10:0] == 11'h001
    && rx_dlc_i == 4'h8;
  assign rx_lo = rx_data_i[15:0];
  sequence s_take; tx_valid_o && tx_ready_i; endsequence
  sequence s_gap; !tx_valid_o ##1 tx_valid_o; endsequence
  property p_gap; s_take |=> s_gap; endproperty
  a_gap: assert property (p_gap) else $error("no gap then frame");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_data_o) && $stable(tx_id_o); endproperty
  a_hold: assert property (p_hold) else $error("frame moved");
  property p_dlc; tx_valid_o |-> tx_dlc_o == 4'h8; endproperty
  a_dlc: assert property (p_dlc) else $error("bad length");
  property p_std; tx_valid_o && !tx_ext_o |-> tx_id_o == 29'h001;
  endproperty
  a_std: assert property (p_std) else $error("bad page id");
  property p_pg; tx_valid_o && !tx_ext_o |->
    tx_data_o[15:0] == {13'h0000, page_o}; endproperty
  a_pg: assert property (p_pg) else $error("bad page index");
  property p_sa; tx_valid_o && tx_ext_o |-> tx_id_o[7:0] ==
    (tsc1_sa_cfg_i[8] ? 8'h03 : tsc1_sa_cfg_i[7:0]); endproperty
  a_sa: assert property (p_sa) else $error("bad source address");
  property p_spd; tx_valid_o && tx_id_o[28:8] == 21'h0C0000 |-> tx_ext_o
    && tx_data_o[63:24] == 40'hFFFFFFFFFF && tx_data_o[7:0] == 8'h01;
  endproperty
  a_spd: assert property (p_spd) else $error("bad speed frame");
  property p_cmd; acc |=> cmd_valid_o && cmd_data_o == $past(rx_lo);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command lost");
  property p_rej; !acc |=> !cmd_valid_o; endproperty
  a_rej: assert property (p_rej) else $error("spurious command");
  property p_rate; bit_cycles_o == 8'h50; endproperty
  a_rate: assert property (p_rate) else $error("bad bit time");
endmodule : can_page_broadcaster_properties

/* File: sim/can_page_broadcaster_tb.sv */
`timescale 1ns/100ps
module can_page_broadcaster_tb;
  logic clk_sys_i = 0, srst_i = 1, meas_wr_i = 0, meas_commit_i = 0;
  logic spd_ctrl_en_i = 0, start_stop_en_i = 0, eng_run_i = 0, stall = 0;
  logic rx_valid_i = 0, rx_ext_i = 0;
  logic clk_en = 1;
  logic [4:0] meas_addr_i = 0;
  logic [15:0] meas_data_i = 0, spd_ref_i = 16'h1234, cmd_data_o;
  logic [8:0] tsc1_sa_cfg_i = 9'h1FF;
  logic [28:0] rx_id_i = 0, tx_id_o;
  logic [3:0] rx_dlc_i = 0, tx_dlc_o;
  logic [63:0] rx_data_i = 0, tx_data_o;
  logic tx_valid_o, tx_ready_i, tx_ext_o, cmd_valid_o;
  logic [7:0] bit_cycles_o;
  logic [2:0] page_o;
  int num_errors = 0, n_checks = 0, cyc = 0;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  can_page_broadcaster #(.TSC1_PERIOD_CYC(200)) u_dut (.clk_sys_i,
    .srst_i, .clk_en_i(clk_en), .meas_wr_i, .meas_addr_i, .meas_data_i,
    .meas_commit_i, .spd_ctrl_en_i, .spd_ref_i, .tsc1_sa_cfg_i,
    .start_stop_en_i, .eng_run_i, .tx_valid_o, .tx_ready_i, .tx_id_o,
    .tx_ext_o, .tx_dlc_o, .tx_data_o, .bit_cycles_o, .rx_valid_i, .rx_id_i,
    .rx_ext_i, .rx_dlc_i, .rx_data_i, .cmd_valid_o, .cmd_data_o, .page_o);
  can_link_model u_link (.clk_i(clk_sys_i), .valid_i(tx_valid_o),
    .id_i(tx_id_o), .ext_i(tx_ext_o), .dlc_i(tx_dlc_o), .data_i(tx_data_o),
    .stall_i(stall), .ready_o(tx_ready_i));
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      final_report();
    end
  end
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task nxt(output logic [28:0] id, output logic x, output logic [63:0] d,
    output int t);
    int w;
    w = 0;
    while (u_link.q_id.size() == 0 && w < 2000) begin
      @(negedge clk_sys_i);
      w++;
    end
    if (w == 2000) begin
      num_errors++;
      final_report();
    end else begin
      id = u_link.q_id.pop_front();
      x = u_link.q_ext.pop_front();
      d = u_link.q_data.pop_front();
      t = u_link.q_t.pop_front();
    end
  endtask : nxt
  task drain;
    repeat (10) @(negedge clk_sys_i);
    u_link.q_id.delete();
    u_link.q_ext.delete();
    u_link.q_data.delete();
    u_link.q_t.delete();
  endtask : drain
  // skips page frames until an engine frame turns up
  task eng(input logic [28:0] ei, input logic [63:0] ed, output int t);
    logic [28:0] id;
    logic x;
    logic [63:0] d;
    x = 0;
    for (int k = 0; k < 200 && !x; k++) nxt(id, x, d, t);
    chk("eng_id", ei, id);
    chk("eng_data", ed, d);
  endtask : eng
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_sys_i);
    meas_wr_i = 1;
    meas_addr_i = a;
    meas_data_i = v;
    @(negedge clk_sys_i);
    meas_wr_i = 0;
  endtask : wr
  task rx(input logic x, input logic [10:0] i, input logic [3:0] l,
    input logic [15:0] v, input logic ok);
    @(negedge clk_sys_i);
    rx_valid_i = 1;
    rx_ext_i = x;
    rx_id_i = {18'h00000, i};
    rx_dlc_i = l;
    rx_data_i = {48'hFFFFFFFFFFFF, v};
    @(negedge clk_sys_i);
    rx_valid_i = 0;
    chk("cmd_valid", ok, cmd_valid_o);
    if (ok) chk("cmd_data", v, cmd_data_o);
  endtask : rx
  function automatic logic [63:0] pl(input logic [2:0] g);
    logic [15:0] w[3];
    for (int n = 0; n < 3; n++)
      w[n] = (g == 0 && n == 0) ? 16'h0001 : 16'(16'hA000 + 3 * g + n);
    return {w[2], w[1], w[0], 8'h00, 5'h00, g};
  endfunction : pl
  initial begin
    logic [28:0] id;
    logic x;
    logic [63:0] d;
    int t0, t1;
    logic [2:0] p;
    repeat (4) @(negedge clk_sys_i);
    srst_i = 0;
    // offsets 0 and 24 must be ignored
    for (int o = 0; o < 25; o++) wr(5'(o), 16'(16'hA000 + o));
    @(negedge clk_sys_i);
    meas_commit_i = 1;
    @(negedge clk_sys_i);
    meas_commit_i = 0;
    drain();
    nxt(id, x, d, t0);
    stall = 1;
    repeat (2) @(negedge clk_sys_i);
    // frozen clock enable: this commit must never reach the frames
    wr(5'h01, 16'hBEEF);
    clk_en = 0;
    meas_commit_i = 1;
    @(negedge clk_sys_i);
    meas_commit_i = 0;
    repeat (14) @(negedge clk_sys_i);
    clk_en = 1;
    @(negedge clk_sys_i);
    stall = 0;
    nxt(id, x, d, t0);
    p = d[2:0];
    for (int k = 0; k < 8; k++) begin
      if (k > 0) nxt(id, x, d, t0);
      chk("page_data", pl(3'(p + k)), d);
    end
    for (int i = 0; i < 2; i++) begin
      tsc1_sa_cfg_i = i ? 9'h042 : 9'h1FF;
      spd_ctrl_en_i = 1;
      eng({21'h0C0000, i ? 8'h42 : 8'h03}, {40'hFFFFFFFFFF, 16'h1234,
        8'h01}, t0);
      eng({21'h0C0000, i ? 8'h42 : 8'h03}, {40'hFFFFFFFFFF, 16'h1234,
        8'h01}, t1);
      chk("period", 1, (t1 - t0) inside {[196:204]});
      spd_ctrl_en_i = 0;
      drain();
    end
    start_stop_en_i = 1;
    eng_run_i = 1;
    eng(29'h18000042, {56'hFFFFFFFFFFFFFF, 8'h01}, t0);
    eng_run_i = 0;
    eng(29'h18000042, {56'hFFFFFFFFFFFFFF, 8'h00}, t0);
    start_stop_en_i = 0;
    rx(0, 11'h001, 4'h8, 16'h0102, 1);
    rx(0, 11'h001, 4'h8, 16'h0304, 1);
    rx(1, 11'h001, 4'h8, 16'h0506, 0);
    rx(0, 11'h002, 4'h8, 16'h0708, 0);
    rx(0, 11'h001, 4'h7, 16'h090A, 0);
    chk("cmd_hold", 16'h0304, cmd_data_o);
    chk("bad_frames", 0, u_link.bad);
    final_report();
  end
endmodule : can_page_broadcaster_tb
bind can_page_broadcaster can_page_broadcaster_properties u_chk (
  .clk_sys_i, .srst_i, .tx_valid_o, .tx_ready_i, .tx_id_o, .tx_ext_o,
  .tx_dlc_o, .tx_data_o, .bit_cycles_o, .rx_valid_i, .rx_id_i, .rx_ext_i,
  .rx_dlc_i, .rx_data_i, .cmd_valid_o, .cmd_data_o, .page_o, .tsc1_sa_cfg_i);

/* File: verilog/can_page_broadcaster.sv */
// How it works
// - link runs at 250 kbps
// - node identifier fixed at 0x01
// - measurement frames use standard 11-bit identifiers
// - every frame carries exactly eight bytes
// - pages broadcast repeatedly without any request
// - commands accepted, outcome only in broadcast data
// - page 0: revision, gen L1-N, L2-N
// - page 1: gen L2-L3, L1-L2, L3-N volts
// - page 2: gen L3-L1 volts, L2, L1 Hz
// - page 3: gen L2 pf, L3 Hz, L1 pf
// - page 4: mains L1-N, gen L3 pf, avg pf
// - page 5: mains L1-L2, L2-N, L3-N volts
// - page 6: mains L1 Hz, L2-L3, L3-L1 volts
// - page 7: load L1 amps, mains L2, L3 Hz
// - speed-control frame every 10 ms when enabled
// - source address -1 means expected default
// - optional start/stop frame decided by external logic via eng_run_i
`timescale 1ns/100ps
`include "can_page_cfg.svh"

module can_page_broadcaster
  import can_page_pkg::*;
#(
  parameter int TSC1_PERIOD_CYC = `TSC1_PERIOD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  // measurement words from the metering logic
  input wire logic meas_wr_i,
  input wire logic [4:0] meas_addr_i,
  input wire logic [15:0] meas_data_i,
  input wire logic meas_commit_i,
  // engine control settings
  input wire logic spd_ctrl_en_i,
  input wire logic [15:0] spd_ref_i,
  input wire logic [8:0] tsc1_sa_cfg_i,
  input wire logic start_stop_en_i,
  input wire logic eng_run_i,
  // frame toward the CAN controller
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [28:0] tx_id_o,
  output logic tx_ext_o,
  output logic [3:0] tx_dlc_o,
  output logic [63:0] tx_data_o,
  output logic [7:0] bit_cycles_o,
  // frame from the CAN controller
  input wire logic rx_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [63:0] rx_data_i,
  output logic cmd_valid_o,
  output logic [15:0] cmd_data_o,
  output logic [2:0] page_o
);

  localparam int TSC1_CNT_W = $clog2(TSC1_PERIOD_CYC + 1);

  word_type live_words [0:`WORD_COUNT-1];
  word_type frozen_words [0:`WORD_COUNT-1];
  fsm_state_type state;
  fsm_state_type next_state;
  source_type src_sel;
  logic [2:0] page_idx;
  logic [TSC1_CNT_W-1:0] tsc1_cnt;
  logic tsc1_due;
  logic tsc1_pend;
  logic ss_pend;
  logic run_seen;
  logic tsc1_tick;
  logic run_change;
  logic load_frame;
  logic frame_done;
  logic cmd_hit;
  logic [7:0] tsc1_sa;

  // byte 0 page, byte 1 zero, then each word low byte first
  function automatic payload_type pack_page(input logic [2:0] page,
                                            input word_type w0,
                                            input word_type w1,
                                            input word_type w2);
    pack_page = {w2[15:8], w2[7:0], w1[15:8], w1[7:0],
                 w0[15:8], w0[7:0], 8'h00, {5'h00, page}};
  endfunction : pack_page

  // word n of page p lives at offset 3p+n
  function automatic payload_type page_frame(input logic [2:0] page);
    word_type w0;
    word_type w1;
    word_type w2;
    w0 = 16'h0000;
    w1 = 16'h0000;
    w2 = 16'h0000;
    case (page)
      3'h0: begin
        w0 = frozen_words[`OFS_PROTOCOL_REVISION];
        w1 = frozen_words[`OFS_GEN_L1N_VOLTS];
        w2 = frozen_words[`OFS_GEN_L2N_VOLTS];
      end
      3'h1: begin
        w0 = frozen_words[`OFS_GEN_L2L3_VOLTS];
        w1 = frozen_words[`OFS_GEN_L1L2_VOLTS];
        w2 = frozen_words[`OFS_GEN_L3N_VOLTS];
      end
      3'h2: begin
        w0 = frozen_words[`OFS_GEN_L3L1_VOLTS];
        w1 = frozen_words[`OFS_GEN_L2_FREQ];
        w2 = frozen_words[`OFS_GEN_L1_FREQ];
      end
      3'h3: begin
        w0 = frozen_words[`OFS_GEN_L2_PF];
        w1 = frozen_words[`OFS_GEN_L3_FREQ];
        w2 = frozen_words[`OFS_GEN_L1_PF];
      end
      3'h4: begin
        w0 = frozen_words[`OFS_MAINS_L1N_VOLTS];
        w1 = frozen_words[`OFS_GEN_L3_PF];
        w2 = frozen_words[`OFS_GEN_AVG_PF];
      end
      3'h5: begin
        w0 = frozen_words[`OFS_MAINS_L1L2_VOLTS];
        w1 = frozen_words[`OFS_MAINS_L2N_VOLTS];
        w2 = frozen_words[`OFS_MAINS_L3N_VOLTS];
      end
      3'h6: begin
        w0 = frozen_words[`OFS_MAINS_L1_FREQ];
        w1 = frozen_words[`OFS_MAINS_L2L3_VOLTS];
        w2 = frozen_words[`OFS_MAINS_L3L1_VOLTS];
      end
      3'h7: begin
        w0 = frozen_words[`OFS_LOAD_L1_AMPS];
        w1 = frozen_words[`OFS_MAINS_L2_FREQ];
        w2 = frozen_words[`OFS_MAINS_L3_FREQ];
      end
      default: begin
        w0 = 16'h0000;
      end
    endcase
    page_frame = pack_page(page, w0, w1, w2);
  endfunction : page_frame

  function automatic payload_type pack_tsc1(input word_type speed);
    pack_tsc1 = {{5{`FILL_BYTE}}, speed[15:8], speed[7:0],
                 `TSC1_MODE_SPEED};
  endfunction : pack_tsc1

  // extended id: fixed base with the source address in the low byte
  function automatic logic [28:0] ext_id(input logic [28:0] base,
                                         input logic [7:0] sa);
    ext_id = {base[28:8], sa};
  endfunction : ext_id

  assign bit_cycles_o = 8'(`BIT_CYCLES);

  // -1 (any negative value) picks the protocol default
  assign tsc1_sa = tsc1_sa_cfg_i[8] ? `TSC1_SA_EXPECTED
                                    : tsc1_sa_cfg_i[7:0];

  // metering writes go to a live bank; revision is read-only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < `WORD_COUNT; i++) begin
        live_words[i] <= 16'h0000;
      end
    end else if (clk_en_i && meas_wr_i &&
                 meas_addr_i < 5'(`WORD_COUNT) &&
                 meas_addr_i != `OFS_PROTOCOL_REVISION) begin
      live_words[meas_addr_i] <= meas_data_i;
    end
  end

  // commit copies a whole update cycle at once
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < `WORD_COUNT; i++) begin
        frozen_words[i] <= 16'h0000;
      end
      frozen_words[`OFS_PROTOCOL_REVISION] <= `PROTO_REV;
    end else if (clk_en_i && meas_commit_i) begin
      for (int i = 1; i < `WORD_COUNT; i++) begin
        frozen_words[i] <= live_words[i];
      end
    end
  end

  // tsc1 period counter, free running while enabled
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tsc1_cnt <= '0;
      tsc1_due <= 1'b0;
    end else if (clk_en_i) begin
      tsc1_due <= 1'b0;
      if (!spd_ctrl_en_i) begin
        tsc1_cnt <= '0;
      end else if (tsc1_cnt == TSC1_CNT_W'(TSC1_PERIOD_CYC - 1)) begin
        tsc1_cnt <= '0;
        tsc1_due <= 1'b1;
      end else begin
        tsc1_cnt <= tsc1_cnt + 1'b1;
      end
    end
  end

  assign tsc1_tick = tsc1_due && spd_ctrl_en_i;

  // run decision change schedules one start/stop frame
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      run_seen <= 1'b0;
    end else if (clk_en_i) begin
      run_seen <= eng_run_i;
    end
  end

  assign run_change = start_stop_en_i && (run_seen != eng_run_i);

  assign frame_done = (state == ST_SEND) && tx_ready_i;
  assign load_frame = (state == ST_IDLE);

  // pending flags: a new event beats the clear of the old one
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tsc1_pend <= 1'b0;
    end else if (clk_en_i) begin
      if (tsc1_tick) begin
        tsc1_pend <= 1'b1;
      end else if (!spd_ctrl_en_i) begin
        tsc1_pend <= 1'b0;
      end else if (load_frame && tsc1_pend) begin
        tsc1_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ss_pend <= 1'b0;
    end else if (clk_en_i) begin
      if (run_change) begin
        ss_pend <= 1'b1;
      end else if (!start_stop_en_i) begin
        ss_pend <= 1'b0;
      end else if (load_frame && !tsc1_pend && ss_pend) begin
        ss_pend <= 1'b0;
      end
    end
  end

  // frame handshake: load in idle, hold until the controller takes it
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  assign tx_valid_o = (state == ST_SEND);

  // engine frames preempt pages only between frames
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      src_sel <= SRC_PAGE;
      tx_id_o <= '0;
      tx_ext_o <= 1'b0;
      tx_dlc_o <= `FRAME_DLC;
      tx_data_o <= '0;
    end else if (clk_en_i && load_frame) begin
      tx_dlc_o <= `FRAME_DLC;
      if (tsc1_pend) begin
        src_sel <= SRC_TSC1;
        tx_ext_o <= 1'b1;
        tx_id_o <= ext_id(`TSC1_ID, tsc1_sa);
        tx_data_o <= pack_tsc1(spd_ref_i);
      end else if (ss_pend) begin
        src_sel <= SRC_START_STOP;
        tx_ext_o <= 1'b1;
        tx_id_o <= ext_id(`START_STOP_ID, tsc1_sa);
        tx_data_o <= {{7{`FILL_BYTE}},
                      eng_run_i ? `ENG_START_CODE
                                : `ENG_STOP_CODE};
      end else begin
        src_sel <= SRC_PAGE;
        tx_ext_o <= 1'b0;
        tx_id_o <= {18'h00000, `NODE_ID};
        tx_data_o <= page_frame(page_idx);
      end
    end
  end

  // round robin advances only once a page frame is taken
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      page_idx <= 3'h0;
    end else if (clk_en_i && frame_done && src_sel == SRC_PAGE) begin
      if (page_idx == `LAST_PAGE) begin
        page_idx <= 3'h0;
      end else begin
        page_idx <= page_idx + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      page_o <= 3'h0;
    end else if (clk_en_i && load_frame && !tsc1_pend && !ss_pend) begin
      page_o <= page_idx;
    end
  end

  // commands: standard id to our node, full payload only
  assign cmd_hit = rx_valid_i && !rx_ext_i &&
                   rx_id_i[10:0] == `NODE_ID &&
                   rx_dlc_i == `FRAME_DLC;

  // no reply frame is built; the outcome shows in the pages
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_data_o <= 16'h0000;
    end else if (clk_en_i) begin
      cmd_valid_o <= cmd_hit;
      if (cmd_hit) begin
        cmd_data_o <= rx_data_i[15:0];
      end
    end
  end

endmodule : can_page_broadcaster

/* File: verilog/can_page_cfg.svh */
`ifndef CAN_PAGE_CFG_SVH
`define CAN_PAGE_CFG_SVH

// link timing
`define CLK_HZ 20000000
`define BIT_RATE_KBPS 250
`define BIT_CYCLES (`CLK_HZ / (`BIT_RATE_KBPS * 1000))
`define TSC1_PERIOD_MS 10
`define TSC1_PERIOD_CYC (`CLK_HZ / 1000 * `TSC1_PERIOD_MS)

// identifiers
`define NODE_ID 11'h001
`define TSC1_ID 29'h0C000003
`define TSC1_SA_EXPECTED 8'h03
`define START_STOP_ID 29'h18000000
`define FRAME_DLC 4'h8

// payload fill and codes
`define FILL_BYTE 8'hFF
`define TSC1_MODE_SPEED 8'h01
`define ENG_START_CODE 8'h01
`define ENG_STOP_CODE 8'h00
`define PROTO_REV 16'h0001

// page layout
`define PAGE_COUNT 8
`define WORDS_PER_PAGE 3
`define WORD_COUNT 24
`define LAST_PAGE 3'h7

// register offsets
`define OFS_PROTOCOL_REVISION 5'h00
`define OFS_GEN_L1N_VOLTS 5'h01
`define OFS_GEN_L2N_VOLTS 5'h02
`define OFS_GEN_L2L3_VOLTS 5'h03
`define OFS_GEN_L1L2_VOLTS 5'h04
`define OFS_GEN_L3N_VOLTS 5'h05
`define OFS_GEN_L3L1_VOLTS 5'h06
`define OFS_GEN_L2_FREQ 5'h07
`define OFS_GEN_L1_FREQ 5'h08
`define OFS_GEN_L2_PF 5'h09
`define OFS_GEN_L3_FREQ 5'h0A
`define OFS_GEN_L1_PF 5'h0B
`define OFS_MAINS_L1N_VOLTS 5'h0C
`define OFS_GEN_L3_PF 5'h0D
`define OFS_GEN_AVG_PF 5'h0E
`define OFS_MAINS_L1L2_VOLTS 5'h0F
`define OFS_MAINS_L2N_VOLTS 5'h10
`define OFS_MAINS_L3N_VOLTS 5'h11
`define OFS_MAINS_L1_FREQ 5'h12
`define OFS_MAINS_L2L3_VOLTS 5'h13
`define OFS_MAINS_L3L1_VOLTS 5'h14
`define OFS_LOAD_L1_AMPS 5'h15
`define OFS_MAINS_L2_FREQ 5'h16
`define OFS_MAINS_L3_FREQ 5'h17

`endif

/* File: verilog/can_page_pkg.sv */
package can_page_pkg;

  typedef logic [15:0] word_type;
  typedef logic [63:0] payload_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } fsm_state_type;

  typedef enum logic [2:0] {
    SRC_PAGE = 3'b001,
    SRC_TSC1 = 3'b010,
    SRC_START_STOP = 3'b100
  } source_type;

endpackage : can_page_pkg
